// ===== design/ssp_pkg.sv
// Package of constants for the synchronous serial port in SPI mode
package ssp_pkg;
    // Register indices as printed; byte address is four times index
    localparam logic [7:0] SSP_IDX_BUF = 8'h13;
    localparam logic [7:0] SSP_IDX_CON = 8'h14;
    localparam logic [7:0] SSP_IDX_STAT = 8'h94;
    localparam logic [7:0] SSP_IDX_IRQ = 8'h20;
    localparam logic [7:0] SSP_IDX_MASK = 8'h21;
    localparam logic [7:0] SSP_IDX_SLEEP = 8'h22;
    localparam int SSP_ADDR_W = 10;
    // Control register fields
    localparam int SSP_CON_WRITE_COLLISION = 7;
    localparam int SSP_CON_OVF = 6;
    localparam int SSP_CON_EN = 5;
    localparam int SSP_CON_CKP = 4;
    // Status register fields
    localparam int SSP_STAT_SMP = 7;
    localparam int SSP_STAT_CKE = 6;
    localparam int SSP_STAT_BF = 0;
    // Interrupt status fields
    localparam int SSP_IRQ_DONE = 0;
    localparam int SSP_IRQ_OVF = 1;
    localparam int SSP_IRQ_WRITE_COLLISION = 2;
    localparam logic [7:0] SSP_CON_RST = 8'h00;
    localparam logic [7:0] SSP_STAT_RST = 8'h00;
    localparam logic [7:0] SSP_MASK_RST = 8'h00;
    localparam int SSP_BITS = 8;
    localparam logic [7:0] SSP_DIV_RST = 8'h03;
    typedef enum logic [1:0] {SSP_BUS_IDLE, SSP_BUS_ANS} ssp_bus_t;
endpackage : ssp_pkg

// ===== design/ssp_spi.sv
// SPI-mode synchronous serial port with Avalon-MM register access
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module ssp_spi
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic sleep,
    input wire logic [ssp_pkg::SSP_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic sdi,
    output logic sdo,
    input wire logic ss_n,
    output logic irq,
    output logic wake
);
    import ssp_pkg::*;

    logic [7:0] con_q;
    logic [7:0] stat_q;
    logic [7:0] buf_q;
    logic [7:0] sh_q;
    logic [3:0] cnt_q;
    logic busy_q;
    logic [7:0] div_q;
    logic [7:0] divcnt_q;
    logic sck_q;
    logic [2:0] isr_q;
    logic [2:0] imask_q;
    logic sck_s;
    logic sdi_s;
    logic ss_s;
    logic sck_prev_q;
    logic sdi_hold_q;
    ssp_bus_t bus_q;

    ssp_sync u_sck (.clk(clk), .rst(rst), .ce(ce), .din(sck_in), .dout(sck_s));
    ssp_sync u_sdi (.clk(clk), .rst(rst), .ce(ce), .din(sdi), .dout(sdi_s));
    ssp_sync u_ss (.clk(clk), .rst(rst), .ce(ce), .din(ss_n), .dout(ss_s));

    function automatic logic hit(input logic [SSP_ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction : hit

    logic enable;
    logic master;
    logic clk_idle;
    logic run;
    logic master_tick;
    logic eff_sck;
    logic eff_prev;
    logic edge_any;
    logic lead_edge;
    logic trail_edge;
    logic shift_edge;
    logic sample_edge;
    logic byte_done;
    logic wr_buf;
    logic rd_buf;
    logic acc;

    assign enable = con_q[SSP_CON_EN];
    assign master = (con_q[3:0] <= 4'h3);
    assign clk_idle = con_q[SSP_CON_CKP];
    // Master halts in sleep and resumes where it stopped
    assign run = ce && enable && !(master && sleep);
    assign master_tick = run && master && busy_q && (divcnt_q == 8'h00);
    assign eff_sck = master ? ~sck_q : sck_s;
    assign eff_prev = master ? sck_q : sck_prev_q;
    // Slave edges come from the pin, so sleep does not gate them
    assign edge_any = master ? master_tick : (run && !ss_s && (sck_s != sck_prev_q));
    // Leading edge leaves idle level
    assign lead_edge = edge_any && (eff_prev == clk_idle);
    assign trail_edge = edge_any && (eff_prev != clk_idle);
    // Edge select 1 transmits on active-to-idle, giving mode 0,0 and 1,0
    assign shift_edge = stat_q[SSP_STAT_CKE] ? trail_edge : lead_edge;
    // Sample phase: end of bit period in master only
    assign sample_edge = (master && stat_q[SSP_STAT_SMP]) ? shift_edge : !shift_edge && edge_any;
    assign byte_done = sample_edge && (cnt_q == 4'(SSP_BITS - 1));
    // Writes land on the edge where the master sees waitrequest low, never earlier
    assign acc = (avs_read || avs_write) && (bus_q == SSP_BUS_ANS);
    assign wr_buf = acc && avs_write && hit(avs_address, SSP_IDX_BUF);
    assign rd_buf = acc && avs_read && hit(avs_address, SSP_IDX_BUF);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bus_q <= SSP_BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            unique case (bus_q)
                SSP_BUS_IDLE:
                begin
                    if (avs_read || avs_write)
                    begin
                        bus_q <= SSP_BUS_ANS;
                        avs_waitrequest <= 1'b0;
                        avs_readdata <= 32'h0000_0000;
                        if (avs_read)
                        begin
                            if (hit(avs_address, SSP_IDX_BUF))
                                avs_readdata[7:0] <= buf_q;
                            else if (hit(avs_address, SSP_IDX_CON))
                                avs_readdata[7:0] <= con_q;
                            else if (hit(avs_address, SSP_IDX_STAT))
                                avs_readdata[7:0] <= stat_q;
                            else if (hit(avs_address, SSP_IDX_IRQ))
                                avs_readdata[2:0] <= isr_q;
                            else if (hit(avs_address, SSP_IDX_MASK))
                                avs_readdata[2:0] <= imask_q;
                            else if (hit(avs_address, SSP_IDX_SLEEP))
                                avs_readdata[7:0] <= div_q;
                        end
                    end
                end
                SSP_BUS_ANS:
                begin
                    bus_q <= SSP_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default:
                begin
                    bus_q <= SSP_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Control: flag bits stay set by hardware; collision and overflow clear by software write, BF by a buffer read
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            con_q <= SSP_CON_RST;
            stat_q <= SSP_STAT_RST;
            div_q <= SSP_DIV_RST;
            imask_q <= 3'h0;
        end
        else if (ce)
        begin
            if (acc && avs_write && hit(avs_address, SSP_IDX_CON))
                con_q[5:0] <= avs_writedata[5:0];
            if (acc && avs_write && hit(avs_address, SSP_IDX_STAT))
                stat_q[7:6] <= avs_writedata[7:6];
            if (acc && avs_write && hit(avs_address, SSP_IDX_MASK))
                imask_q <= avs_writedata[2:0];
            if (acc && avs_write && hit(avs_address, SSP_IDX_SLEEP))
                div_q <= avs_writedata[7:0];
            // Set wins over a same-cycle clear
            if (acc && avs_write && hit(avs_address, SSP_IDX_CON) && !avs_writedata[SSP_CON_WRITE_COLLISION])
                con_q[SSP_CON_WRITE_COLLISION] <= 1'b0;
            if (acc && avs_write && hit(avs_address, SSP_IDX_CON) && !avs_writedata[SSP_CON_OVF])
                con_q[SSP_CON_OVF] <= 1'b0;
            if (wr_buf && busy_q)
                con_q[SSP_CON_WRITE_COLLISION] <= 1'b1;
            if (byte_done && stat_q[SSP_STAT_BF])
                con_q[SSP_CON_OVF] <= 1'b1;
            if (rd_buf)
                stat_q[SSP_STAT_BF] <= 1'b0;
            if (byte_done)
                stat_q[SSP_STAT_BF] <= 1'b1;
        end
    end

    // Shift engine; disabled port holds idle and drops any transfer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sh_q <= 8'h00;
            buf_q <= 8'h00;
            cnt_q <= 4'h0;
            busy_q <= 1'b0;
            divcnt_q <= 8'h00;
            sck_q <= 1'b0;
            sck_prev_q <= 1'b0;
            sdi_hold_q <= 1'b0;
            sdo <= 1'b0;
        end
        else if (ce)
        begin
            sck_prev_q <= sck_s;
            if (!enable)
            begin
                busy_q <= 1'b0;
                cnt_q <= 4'h0;
                sck_q <= clk_idle;
            end
            else
            begin
                if (!busy_q)
                    sck_q <= clk_idle;
                if (wr_buf && !busy_q)
                begin
                    sh_q <= avs_writedata[7:0];
                    sdo <= avs_writedata[7];
                    busy_q <= master;
                    divcnt_q <= div_q;
                end
                if (!master && ss_s)
                    cnt_q <= 4'h0;
                if (run && master && busy_q)
                begin
                    divcnt_q <= (divcnt_q == 8'h00) ? div_q : divcnt_q - 8'h01;
                    if (master_tick)
                        sck_q <= ~sck_q;
                end
                if (sample_edge)
                    sdi_hold_q <= sdi_s;
                // Late sampling shifts on this same edge, so the next bit sits one place lower
                if (shift_edge && (stat_q[SSP_STAT_CKE] || cnt_q != 4'h0))
                    sdo <= sample_edge ? sh_q[6] : sh_q[7];
                if (sample_edge)
                begin
                    sh_q <= {sh_q[6:0], sdi_s};
                    cnt_q <= cnt_q + 4'h1;
                end
                if (byte_done)
                begin
                    buf_q <= {sh_q[6:0], sdi_s};
                    cnt_q <= 4'h0;
                    busy_q <= 1'b0;
                end
            end
        end
    end

    // Sticky events, write one to clear, set wins
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            isr_q <= 3'h0;
            irq <= 1'b0;
            wake <= 1'b0;
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
        end
        else if (ce)
        begin
            isr_q <= (isr_q & ~((acc && avs_write && hit(avs_address, SSP_IDX_IRQ)) ? avs_writedata[2:0] : 3'h0))
                | {wr_buf && busy_q, byte_done && stat_q[SSP_STAT_BF], byte_done};
            irq <= |(isr_q & imask_q);
            wake <= sleep && isr_q[SSP_IRQ_DONE] && imask_q[SSP_IRQ_DONE];
            sck_out <= sck_q;
            sck_oe <= enable && master;
        end
    end
endmodule : ssp_spi

// ===== design/ssp_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module ssp_sync
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            // Slave shifting must continue in sleep, so only ce gates this
            if (ce)
            begin
                s1_q <= din;
                s2_q <= s1_q;
                s3_q <= s2_q;
            end
        end
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dout <= 1'b0;
        end
        else if (ce && (s2_q == s3_q))
        begin
            dout <= s3_q;
        end
    end
endmodule : ssp_sync

// ===== tb/ssp_slave_model.sv
// Behavioural SPI slave device facing the master port
`timescale 1ns/1ps
module ssp_slave_model
(
    input wire logic clk,
    input wire logic sck,
    input wire logic oe,
    input wire logic mosi,
    input wire logic cpol,
    input wire logic cke,
    input wire logic load,
    input wire logic [7:0] tx,
    output logic miso,
    output logic [7:0] rx_q
);
    logic sck_q = 0;
    logic [7:0] sh_q = 0;
    int n_q = 8;
    initial miso = 0;
    initial rx_q = 0;
    always @(posedge clk)
    begin
        sck_q <= sck;
        if (load)
        begin
            sh_q <= tx;
            miso <= tx[7];
            n_q <= 0;
        end
        else if (!oe || n_q == 8)
            miso <= ~miso; // Outside a frame the line holds no value
        else if (sck != sck_q && sck == (cpol ^ cke))
        begin
            rx_q <= {rx_q[6:0], mosi};
            n_q <= n_q + 1;
        end
        else if (sck != sck_q && n_q > 0)
        begin
            sh_q <= sh_q << 1;
            miso <= sh_q[6];
        end
    end
endmodule : ssp_slave_model

// ===== tb/ssp_spi_assertions.sv
// Port-level assertions for the SPI port
`timescale 1ns/1ps
module ssp_spi_chk
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sleep,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic sdo,
    input wire logic irq,
    input wire logic wake
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered");
    AST_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held too long");
    AST_IDLE: assert property (!avs_read && !avs_write |=> avs_waitrequest && $stable(avs_readdata))
        else $error("idle bus moved");
    AST_RST: assert property (disable iff (1'b0) rst |=> avs_waitrequest && !irq && !wake && !sck_oe && !sck_out && !sdo)
        else $error("outputs not cleared by reset");
    AST_WAKE_SLEEP: assert property (wake |-> $past(sleep))
        else $error("wake without sleep");
    AST_WAKE_IRQ: assert property (wake |-> irq)
        else $error("wake without interrupt");
    AST_FREEZE_SCK: assert property (sleep && $past(sleep) && sck_oe |=> $stable(sck_out))
        else $error("clock moved in sleep");
    AST_FREEZE_SDO: assert property (sleep && $past(sleep) && sck_oe |=> $stable(sdo))
        else $error("data moved in sleep");
    cover property (sleep && sck_oe);
    cover property (wake);
    cover property ($rose(irq));
endmodule : ssp_spi_chk
bind ssp_spi ssp_spi_chk chk (.clk(clk), .rst(rst), .sleep(sleep), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sck_out(sck_out), .sck_oe(sck_oe),
    .sdo(sdo), .irq(irq), .wake(wake));

// ===== tb/tb_sync_serial_spi_port.sv
// Self-checking bench for the SPI port
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module tb_sync_serial_spi_port;
    import ssp_pkg::*;
    logic clk = 0, rst = 1, sleep = 0, rd = 0, wr = 0, sck_in = 0, sdt = 0, ss_n = 1, slv = 0, tgl = 0, ld = 0;
    logic cpol = 0, cke = 0, wq, sck_out, sck_oe, sdo, irq, wake, miso;
    logic [9:0] addr = 0;
    logic [31:0] wd = 0, rdat, rv, seed = 32'hd134;
    logic [7:0] tx = 0, rx, b;
    int error_cnt = 0, checked = 0, n;
    int exp_q[$];
    wire sdi = slv ? (ss_n ? tgl : sdt) : miso;
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) tgl <= ~tgl;
    ssp_spi dut (.clk(clk), .rst(rst), .ce(1'b1), .sleep(sleep), .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wq), .sck_in(sck_in), .sck_out(sck_out),
        .sck_oe(sck_oe), .sdi(sdi), .sdo(sdo), .ss_n(ss_n), .irq(irq), .wake(wake));
    ssp_slave_model pm (.clk(clk), .sck(sck_out), .oe(sck_oe), .mosi(sdo), .cpol(cpol), .cke(cke), .load(ld),
        .tx(tx), .miso(miso), .rx_q(rx));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic stop_test();
        if (error_cnt == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    // Holds the request until waitrequest is seen low
    task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
        n = 0;
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wq !== 1'b0 && n < 100)
        begin
            n++;
            @(posedge clk);
        end
        `CHK(n < 100, 1'b1)
        rv = rdat;
        wr <= 0;
        rd <= 0;
        @(posedge clk);
    endtask : acc
    task automatic rc(input logic [9:0] a, input logic [7:0] e);
        acc(0, a, 32'h0);
        `CHK(rv[7:0], e)
    endtask : rc
    task automatic wt(input logic w);
        n = 0;
        while ((w ? wake : irq) !== 1'b1 && n < 1000)
        begin
            n++;
            @(posedge clk);
        end
        `CHK(n < 1000, 1'b1)
    endtask : wt
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rc(10'h50, SSP_CON_RST);
        rc(10'h250, SSP_STAT_RST);
        rc(10'h84, SSP_MASK_RST);
        rc(10'h88, SSP_DIV_RST);
        rc(10'h3fc, 8'h00);
        acc(1, 10'h88, 32'h7);
        acc(1, 10'h84, 32'h1);
        for (int m = 0; m < 4; m++)
        begin
            cpol <= m[1];
            cke <= !m[0];
            acc(1, 10'h250, {24'h0, m == 0, !m[0], 6'h0});
            acc(1, 10'h50, {26'h0, 1'b1, m[1], 4'h0});
            seed = xs(seed);
            tx <= seed[7:0];
            exp_q.push_back(seed[7:0]);
            b = seed[15:8];
            ld <= 1;
            @(posedge clk);
            ld <= 0;
            acc(1, 10'h4c, {24'h0, b});
            if (m == 3)
            begin
                acc(1, 10'h4c, 32'h0);
                rc(10'h50, 8'hb0);
                `CHK(irq, 1'b0)
                acc(1, 10'h50, 32'h30);
            end
            repeat (20) @(posedge clk);
            sleep <= 1;
            repeat (40) @(posedge clk);
            `CHK(irq, 1'b0)
            sleep <= 0;
            wt(0);
            rc(10'h250, {m == 0, !m[0], 6'h1});
            rc(10'h80, (m == 3) ? 8'h05 : 8'h01);
            acc(1, 10'h80, 32'h7);
            rc(10'h4c, exp_q.pop_front());
            rc(10'h250, {m == 0, !m[0], 6'h0});
            `CHK(rx, b)
            `CHK(irq, 1'b0)
        end
        acc(1, 10'h4c, 32'h5a);
        repeat (30) @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        `CHK(sck_oe, 1'b0)
        rc(10'h50, 8'h00);
        rc(10'h80, 8'h00);
        acc(1, 10'h84, 32'h1);
        acc(1, 10'h250, 32'h40);
        acc(1, 10'h50, 32'h24);
        slv <= 1;
        sleep <= 1;
        seed = xs(seed);
        b = seed[7:0];
        ss_n <= 0;
        for (int i = 7; i >= 0; i--)
        begin
            sdt <= b[i];
            repeat (4) @(posedge clk);
            sck_in <= 1;
            repeat (4) @(posedge clk);
            sck_in <= 0;
        end
        repeat (4) @(posedge clk);
        ss_n <= 1;
        wt(1);
        sleep <= 0;
        rc(10'h4c, b);
        rc(10'h80, 8'h01);
        stop_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
endmodule : tb_sync_serial_spi_port
